// file: verilog/cm_pkg.sv
// Purpose: Shared constants and types for the clock multiplier control block.
// Assumes: Core clock of 100 MHz; oscillator inputs sampled on that clock.
// Notes: The minimum multiplier input frequency is a plain default, tune per process.
package cm_pkg;
	// Control register location on the special-function bus
	localparam logic [7:0] CM_CTRL_ADDR = 8'h97;
	localparam logic [7:0] CM_CTRL_PAGE = 8'h0F;
	localparam logic [7:0] CM_CTRL_RESET = 8'h00;
	// Field positions inside the control register
	localparam int CM_EN_BIT = 7;
	localparam int CM_INIT_BIT = 6;
	localparam int CM_RDY_BIT = 5;
	localparam int CM_DIV_LSB = 2;
	localparam int CM_SEL_LSB = 0;
	// Input select: bit 0 picks external, bit 1 set means undivided
	localparam int CM_SEL_EXT_BIT = 0;
	localparam int CM_SEL_FULL_BIT = 1;
	// Timing of the digital multiplier model
	localparam int CM_CLK_MHZ = 100;
	localparam int CM_FCM_MIN_KHZ = 2000;
	localparam int CM_MULT = 4;
	localparam int CM_EDGES_PER_REF = 2 * CM_MULT;
	localparam int CM_CNT_W = 16;
	localparam logic [CM_CNT_W-1:0] CM_STEP_MAX =
		CM_CNT_W'(CM_CLK_MHZ * 1000 / CM_FCM_MIN_KHZ / CM_EDGES_PER_REF);
	localparam logic [3:0] CM_EDGES_INIT = 4'(CM_EDGES_PER_REF);
	localparam logic [2:0] CM_LOCK_EDGES = 3'h4;

	typedef enum logic [1:0] {
		CM_OFF = 2'b00,
		CM_ENABLED = 2'b01,
		CM_LOCKING = 2'b11,
		CM_READY = 2'b10
	} cm_state_e;

	// Scaling field to output period in half-periods of the 4x base clock
	function automatic logic [2:0] cm_div_len(input logic [2:0] f);
		logic [2:0] len;
		case (f)
			3'h3: len = 3'h3;
			3'h4: len = 3'h4;
			3'h5: len = 3'h5;
			3'h6: len = 3'h6;
			3'h7: len = 3'h7;
			default: len = 3'h2;
		endcase
		return len;
	endfunction
endpackage

// file: verilog/cm_gen_if.sv
// Purpose: Link between register control and the multiplier generator.
// Assumes: Single clock domain.
// Notes: run low holds the generator cleared.
`timescale 1ns/1ps
interface cm_gen_if;
	logic run;
	logic [1:0] sel;
	logic [2:0] div;
	logic ready;
	modport ctrl (output run, output sel, output div, input ready);
	modport gen (input run, input sel, input div, output ready);
endinterface

// file: verilog/cm_gen.sv
// Purpose: Digital model of the multiplier: 8 edges per reference period, scaled.
// Assumes: Oscillator levels are synchronous to clk_i.
// Notes: Below the minimum input frequency, edges come at the spacing of the minimum input frequency, then hold.
`timescale 1ns/1ps
module cm_gen (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic int_osc_i,
	input wire logic ext_osc_i,
	cm_gen_if.gen gi,
	output logic mul_clk_o
);
	import cm_pkg::*;

	typedef struct packed {
		logic prev;
		logic half;
		logic [CM_CNT_W-1:0] per_cnt;
		logic [CM_CNT_W-1:0] period;
		logic [CM_CNT_W-1:0] step_cnt;
		logic [3:0] edges_left;
		logic [2:0] lock_cnt;
		logic [2:0] phase;
		logic clk_out;
	} cm_gen_s;

	localparam cm_gen_s GEN_RESET = '0;

	cm_gen_s s_r;
	cm_gen_s s_nxt;
	logic ref_rise;
	logic edge_ev;
	logic [2:0] len;

	// Reference pick, halving, period measure, edge spacing and output divide
	always_comb begin
		logic ref_lvl;
		logic src_rise;
		logic [CM_CNT_W-1:0] step;
		ref_lvl = 1'b0;
		src_rise = 1'b0;
		step = '0;
		s_nxt = s_r;
		edge_ev = 1'b0;
		len = cm_div_len(gi.div);
		ref_lvl = gi.sel[CM_SEL_EXT_BIT] ? ext_osc_i : int_osc_i;
		src_rise = ref_lvl & ~s_r.prev;
		// Halved sources take every second rising edge
		ref_rise = src_rise & (gi.sel[CM_SEL_FULL_BIT] | ~s_r.half);
		s_nxt.prev = ref_lvl;
		s_nxt.half = s_r.half ^ src_rise;
		step = {3'b000, s_r.period[CM_CNT_W-1:3]};
		// Clip spacing so slow inputs give fast bursts, not a stretched clock
		if (step > CM_STEP_MAX) begin
			step = CM_STEP_MAX;
		end
		if (step == '0) begin
			step = {{(CM_CNT_W-1){1'b0}}, 1'b1};
		end
		if (s_r.per_cnt != '1) begin
			s_nxt.per_cnt = s_r.per_cnt + 1'b1;
		end
		if (ref_rise) begin
			s_nxt.period = s_r.per_cnt;
			s_nxt.per_cnt = '0;
			s_nxt.edges_left = CM_EDGES_INIT;
			s_nxt.step_cnt = '0;
			if (s_r.lock_cnt != CM_LOCK_EDGES) begin
				s_nxt.lock_cnt = s_r.lock_cnt + 1'b1;
			end
		end else if (s_r.edges_left != 4'h0) begin
			if (s_r.step_cnt + 1'b1 >= step) begin
				s_nxt.step_cnt = '0;
				s_nxt.edges_left = s_r.edges_left - 1'b1;
				edge_ev = 1'b1;
			end else begin
				s_nxt.step_cnt = s_r.step_cnt + 1'b1;
			end
		end
		// Output period of len base half-periods gives 4x times 2/len
		if (edge_ev) begin
			s_nxt.phase = (s_r.phase + 1'b1 >= len) ? 3'h0 : s_r.phase + 1'b1;
		end
		// Odd len leaves high longer than low
		s_nxt.clk_out = (s_r.lock_cnt == CM_LOCK_EDGES) &&
			({1'b0, s_nxt.phase} < ({1'b0, len} + 4'h1) >> 1);
		if (!gi.run) begin
			s_nxt = GEN_RESET;
			s_nxt.prev = ref_lvl;
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= GEN_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign gi.ready = (s_r.lock_cnt == CM_LOCK_EDGES);
	assign mul_clk_o = s_r.clk_out;

	burst_reload_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		gi.run && ref_rise |=> s_r.edges_left == CM_EDGES_INIT)
		else $error("reference edge did not reload the edge burst");
	phase_range_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		s_r.phase < cm_div_len(gi.div) || $changed(gi.div))
		else $error("output phase ran past the scaling length");
	clk_gated_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!gi.ready |=> !mul_clk_o || gi.ready)
		else $error("output clock ran before lock");
endmodule

// file: verilog/cm_clock_multiplier_control.sv
// Purpose: Control register and sequencing of the on-chip clock multiplier.
// Assumes: Special-function bus strobes are synchronous one-cycle pulses.
// Notes: Read data appears the cycle after the read strobe.
// Summary of operation
// - Output clock is four times selected input, times programmed scaling factor.
// - Inputs offered: internal and external, each either undivided or halved.
// - Select 00 internal x2, 01 external x2, 10 internal x4, 11 external.
// - Slow input gives eight fast edges per reference period (four output periods at scaling 1), then holds.
// - Bit 7 enables the multiplier; zero disables it.
// - Bit 6 reads zero when enabled; writing one then starts initialise.
// - Bit 5 is read-only ready, one only after lock.
// - Bits 4:2 scale by 1,1,1,2/3,1/2,2/5,1/3,2/7.
// - Scaling 2/3, 2/5, 2/7 may give unequal high and low times.
// - Bits 1:0 choose the clock source fed to the multiplier.
// - Register sits at address 0x97, page 0x0F; resets to zero.
`timescale 1ns/1ps
module cm_clock_multiplier_control (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_page_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic int_osc_i,
	input wire logic ext_osc_i,
	output logic mul_clk_o,
	output logic multiplier_enable_o,
	output logic multiplier_ready_o
);
	import cm_pkg::*;

	typedef struct packed {
		logic en;
		logic init_mem;
		logic [2:0] div;
		logic [1:0] sel;
		cm_state_e state;
		logic [7:0] rdata;
	} cm_ctrl_s;

	localparam cm_ctrl_s CTRL_RESET = '{
		en: CM_CTRL_RESET[CM_EN_BIT],
		init_mem: CM_CTRL_RESET[CM_INIT_BIT],
		div: CM_CTRL_RESET[CM_DIV_LSB +: 3],
		sel: CM_CTRL_RESET[CM_SEL_LSB +: 2],
		state: CM_OFF,
		rdata: 8'h00
	};

	cm_ctrl_s s_r;
	cm_ctrl_s s_nxt;
	logic hit;
	logic wr_hit;
	logic rd_hit;
	logic init_req;
	logic [7:0] read_val;

	cm_gen_if gi ();

	// Address decode on the special-function bus
	assign hit = (sfr_addr_i == CM_CTRL_ADDR) && (sfr_page_i == CM_CTRL_PAGE);
	assign wr_hit = sfr_wr_i && hit;
	assign rd_hit = sfr_rd_i && hit;
	// Initialise only counts once the multiplier was already enabled
	assign init_req = wr_hit && s_r.en && sfr_wdata_i[CM_EN_BIT] &&
		sfr_wdata_i[CM_INIT_BIT];

	// Read view: initialise bit hidden while enabled, ready is live state
	always_comb begin
		read_val = 8'h00;
		read_val[CM_EN_BIT] = s_r.en;
		read_val[CM_INIT_BIT] = s_r.en ? 1'b0 : s_r.init_mem;
		read_val[CM_RDY_BIT] = (s_r.state == CM_READY);
		read_val[CM_DIV_LSB +: 3] = s_r.div;
		read_val[CM_SEL_LSB +: 2] = s_r.sel;
	end

	// Register writes and the enable / initialise / lock sequence
	always_comb begin
		s_nxt = s_r;
		if (wr_hit) begin
			s_nxt.en = sfr_wdata_i[CM_EN_BIT];
			s_nxt.div = sfr_wdata_i[CM_DIV_LSB +: 3];
			s_nxt.sel = sfr_wdata_i[CM_SEL_LSB +: 2];
			// Only remembered while disabled; reads zero once enabled
			s_nxt.init_mem = sfr_wdata_i[CM_INIT_BIT] & ~sfr_wdata_i[CM_EN_BIT];
		end
		case (s_r.state)
			CM_OFF: begin
				if (wr_hit && sfr_wdata_i[CM_EN_BIT]) begin
					s_nxt.state = CM_ENABLED;
				end
			end
			CM_ENABLED: begin
				if (init_req) begin
					s_nxt.state = CM_LOCKING;
				end
			end
			CM_LOCKING: begin
				// A fresh initialise write holds off ready for one more cycle
				if (gi.ready && !init_req) begin
					s_nxt.state = CM_READY;
				end
			end
			CM_READY: begin
				// A fresh initialise re-enters locking; the generator keeps its lock, so ready returns next cycle
				if (init_req) begin
					s_nxt.state = CM_LOCKING;
				end
			end
			default: begin
				s_nxt.state = CM_OFF;
			end
		endcase
		// Disable wins over everything, including a zero write
		if (wr_hit && !sfr_wdata_i[CM_EN_BIT]) begin
			s_nxt.state = CM_OFF;
		end
		// Registered read data; unmapped reads return zero
		if (sfr_rd_i) begin
			s_nxt.rdata = hit ? read_val : 8'h00;
		end
	end

	// State register, all zero after reset
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= CTRL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Generator runs only while initialising or locked
	assign gi.run = (s_r.state == CM_LOCKING) || (s_r.state == CM_READY);
	assign gi.sel = s_r.sel;
	assign gi.div = s_r.div;

	cm_gen u_gen (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.int_osc_i(int_osc_i),
		.ext_osc_i(ext_osc_i),
		.gi(gi),
		.mul_clk_o(mul_clk_o)
	);

	assign sfr_rdata_o = s_r.rdata;
	assign multiplier_enable_o = s_r.en;
	assign multiplier_ready_o = (s_r.state == CM_READY);

	// Checks on the register and sequencing behaviour
	sequence init_req_s;
		init_req;
	endsequence
	sequence locking_s;
		s_r.state == CM_LOCKING && !multiplier_ready_o;
	endsequence
	sequence disable_s;
		wr_hit && !sfr_wdata_i[CM_EN_BIT];
	endsequence
	sequence stopped_s;
		!multiplier_ready_o && !gi.run ##1 !mul_clk_o;
	endsequence

	property init_starts_p;
		@(posedge clk_i) disable iff (!nrst_i) init_req_s |=> locking_s;
	endproperty
	property disable_stops_p;
		@(posedge clk_i) disable iff (!nrst_i) disable_s |=> stopped_s;
	endproperty

	init_start_a: assert property (init_starts_p)
		else $error("initialise write did not start locking");
	disable_stop_a: assert property (disable_stops_p)
		else $error("clearing enable did not stop the multiplier");
	init_ignored_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_hit && !s_r.en && s_r.state == CM_OFF |=> s_r.state != CM_LOCKING)
		else $error("initialise accepted while disabled");
	enable_bit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_hit |=> multiplier_enable_o == $past(sfr_wdata_i[CM_EN_BIT]))
		else $error("enable bit not taken from write");
	zero_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_hit && sfr_wdata_i == 8'h00 |=> read_val == 8'h00)
		else $error("zero write left fields set");
	ready_lock_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(multiplier_ready_o) |-> $past(gi.ready) && s_r.en)
		else $error("ready rose without lock");
	init_reads_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rd_hit && s_r.en |=> sfr_rdata_o[CM_INIT_BIT] == 1'b0)
		else $error("initialise bit read one while enabled");
	ready_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rd_hit |=> sfr_rdata_o[CM_RDY_BIT] == $past(multiplier_ready_o))
		else $error("ready bit read differs from state");
	unmapped_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		sfr_rd_i && !hit |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read returned data");

	// Field writes land, and nothing moves without a write
	div_taken_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_hit |=> gi.div == $past(sfr_wdata_i[CM_DIV_LSB +: 3]))
		else $error("scaling field not taken from write");
	sel_taken_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_hit |=> gi.sel == $past(sfr_wdata_i[CM_SEL_LSB +: 2]))
		else $error("input select not taken from write");
	fields_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!wr_hit |=> $stable(gi.div) && $stable(gi.sel))
		else $error("fields changed without a write");
	enable_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!wr_hit |=> $stable(multiplier_enable_o))
		else $error("enable changed without a write");
	miss_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		sfr_wr_i && !hit |=> $stable(gi.div) && $stable(gi.sel))
		else $error("write elsewhere changed the fields");
	page_miss_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		sfr_wr_i && sfr_page_i != CM_CTRL_PAGE |=> $stable(multiplier_enable_o))
		else $error("write on another page changed enable");

	// Sequencer follows the enable bit; ready only leaves on a write
	off_state_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(s_r.state == CM_OFF) == !multiplier_enable_o)
		else $error("sequencer state disagrees with enable bit");
	enable_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		s_r.state == CM_OFF && wr_hit && sfr_wdata_i[CM_EN_BIT] |=> s_r.state == CM_ENABLED)
		else $error("enable write did not leave the off state");
	enabled_wait_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		s_r.state == CM_ENABLED && !wr_hit |=> s_r.state == CM_ENABLED)
		else $error("left enabled state without a write");
	locking_wait_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		s_r.state == CM_LOCKING && !gi.ready |=> !multiplier_ready_o)
		else $error("ready set before the generator locked");
	lock_to_ready_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		s_r.state == CM_LOCKING && gi.ready && !wr_hit |=> multiplier_ready_o)
		else $error("lock did not raise ready");
	ready_stays_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		multiplier_ready_o && !wr_hit |=> multiplier_ready_o)
		else $error("ready dropped without a write");
	relock_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		init_req && multiplier_ready_o |=> !multiplier_ready_o)
		else $error("initialise while ready did not restart locking");
	ready_needs_en_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		multiplier_ready_o |-> multiplier_enable_o)
		else $error("ready set while disabled");

	// Generator held off outside locking and ready
	run_needs_en_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		gi.run |-> multiplier_enable_o)
		else $error("generator running while disabled");
	run_drop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		disable_s |=> !gi.run)
		else $error("clearing enable left the generator running");
	gen_held_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		s_r.state == CM_OFF |=> !gi.run)
		else $error("generator started straight from off");
	init_refused_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_hit && !s_r.en |=> !gi.run)
		else $error("write while disabled started the generator");
	run_stop_ready_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!gi.run |=> !gi.ready)
		else $error("generator kept lock while stopped");
	run_stop_clk_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!gi.run |=> !mul_clk_o)
		else $error("output clock ran while stopped");
	clk_locked_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		mul_clk_o |-> gi.ready)
		else $error("output clock high without lock");

	// Read view and read data
	rdata_stands_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!sfr_rd_i |=> $stable(sfr_rdata_o))
		else $error("read data changed without a read");
	read_enable_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rd_hit |=> sfr_rdata_o[CM_EN_BIT] == $past(multiplier_enable_o))
		else $error("enable bit read differs from state");
	read_div_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rd_hit |=> sfr_rdata_o[CM_DIV_LSB +: 3] == $past(gi.div))
		else $error("scaling field read differs from state");
	read_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rd_hit |=> sfr_rdata_o[CM_SEL_LSB +: 2] == $past(gi.sel))
		else $error("input select read differs from state");
	init_mem_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_hit && !sfr_wdata_i[CM_EN_BIT] |=>
		read_val[CM_INIT_BIT] == $past(sfr_wdata_i[CM_INIT_BIT]))
		else $error("initialise bit not kept while disabled");
	init_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_hit && sfr_wdata_i[CM_EN_BIT] |=> read_val[CM_INIT_BIT] == 1'b0)
		else $error("initialise bit visible after enabling write");
	ready_view_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		read_val[CM_RDY_BIT] == multiplier_ready_o)
		else $error("ready bit view differs from state");

	// Reset value of the whole register
	reset_value_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |-> read_val == CM_CTRL_RESET && sfr_rdata_o == CM_CTRL_RESET)
		else $error("register not at reset value after reset");
endmodule

// file: sim/clock_multiplier_control_bench.sv
// Purpose: Self-checking bench for the clock multiplier control register and output.
// Assumes: Oscillators are made here as slow square waves synchronous to clk_i.
// Notes: Output rate is judged by counting rises over whole reference periods, +/-1.
`timescale 1ns/1ps
module clock_multiplier_control_bench;
	import cm_pkg::*;
	localparam logic [7:0] A = 8'h97;
	localparam logic [7:0] P = 8'h0F;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00;
	logic [7:0] sfr_page_i = 8'h00;
	logic sfr_wr_i = 1'b0;
	logic sfr_rd_i = 1'b0;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic [7:0] sfr_rdata_o;
	logic int_osc_i = 1'b0;
	logic ext_osc_i = 1'b0;
	logic mul_clk_o;
	logic multiplier_enable_o;
	logic multiplier_ready_o;
	int err_total = 0;
	int samples_checked = 0;
	int rises = 0;
	int osc_cnt = 0;
	logic mul_q = 1'b0;

	cm_clock_multiplier_control dut (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
		.sfr_page_i(sfr_page_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .int_osc_i(int_osc_i),
		.ext_osc_i(ext_osc_i), .mul_clk_o(mul_clk_o), .multiplier_enable_o(multiplier_enable_o),
		.multiplier_ready_o(multiplier_ready_o));

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// Internal period 40 cycles, external 60; far below the recommended output band,
	// since a faster reference cannot be modelled on the core clock
	always @(negedge clk_i) begin
		osc_cnt <= osc_cnt + 1;
		if (osc_cnt % 20 == 19) int_osc_i <= ~int_osc_i;
		// External source runs from reset, so it is stable long before any initialise
		if (osc_cnt % 30 == 29) ext_osc_i <= ~ext_osc_i;
	end

	// Rising edges of the multiplied output, sampled mid-cycle where it has settled
	always @(negedge clk_i) begin
		mul_q <= mul_clk_o;
		if (mul_clk_o === 1'b1 && mul_q === 1'b0) rises <= rises + 1;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_page_i = p;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(negedge clk_i);
		sfr_wr_i = 1'b0;
	endtask

	// Data is taken a full cycle after the strobe edge, where it stands settled
	task automatic rd(input logic [7:0] a, input logic [7:0] p, output logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_page_i = p;
		sfr_rd_i = 1'b1;
		@(negedge clk_i);
		sfr_rd_i = 1'b0;
		@(negedge clk_i);
		d = sfr_rdata_o;
	endtask

	task automatic wait_ready(input int limit);
		int i;
		i = 0;
		while (multiplier_ready_o !== 1'b1 && i < limit) begin
			cyc(1);
			i++;
		end
		if (multiplier_ready_o !== 1'b1) begin
			check(multiplier_ready_o, 1'b1);
			complete_run();
		end
	endtask

	// Full documented bring-up: clear, fields, enable, settle, initialise, poll
	task automatic bring_up(input logic [1:0] sel, input logic [2:0] div);
		wr(A, P, 8'h00);
		wr(A, P, {3'b000, div, sel});
		wr(A, P, {3'b100, div, sel});
		cyc(510);
		wr(A, P, {3'b110, div, sel});
		wait_ready(3000);
	endtask

	task automatic t_reset();
		logic [7:0] d;
		rd(A, P, d);
		check(d, 8'h00);
		rd(8'h96, P, d);
		check(d, 8'h00);
		check(multiplier_ready_o, 1'b0);
	endtask

	// Refused writes: wrong page, initialise while disabled, bit 5 read-only
	task automatic t_refused();
		logic [7:0] d;
		wr(A, 8'h00, 8'h80);
		check(multiplier_enable_o, 1'b0);
		wr(A, P, 8'h7F);
		rd(A, P, d);
		check(d, 8'h5F);
		wr(A, P, 8'hC0);
		check(multiplier_enable_o, 1'b1);
		cyc(700);
		check(multiplier_ready_o, 1'b0);
		rd(A, P, d);
		check(d, 8'h80);
	endtask

	// Output rate for every source and every scaling code
	task automatic t_scale();
		int per[4] = '{80, 120, 40, 60};
		int len[8] = '{2, 2, 2, 3, 4, 5, 6, 7};
		logic [1:0] sel;
		logic [2:0] div;
		logic [7:0] d;
		int r0;
		int ex;
		for (int k = 0; k < 11; k++) begin
			sel = (k < 4) ? 2'(k) : 2'b10;
			div = (k < 4) ? 3'b000 : 3'(k - 3);
			bring_up(sel, div);
			rd(A, P, d);
			check(d, {3'b101, div, sel});
			r0 = rises;
			cyc(12 * per[sel]);
			ex = 12 * 8 / len[div];
			check((rises - r0 >= ex - 1) && (rises - r0 <= ex + 1), 1'b1);
		end
	endtask

	task automatic t_disable();
		logic [7:0] d;
		int r0;
		bring_up(2'b00, 3'b000);
		wr(A, P, 8'hC0);
		check(multiplier_ready_o, 1'b0);
		wait_ready(3000);
		wr(A, P, 8'h00);
		check(multiplier_ready_o, 1'b0);
		check(multiplier_enable_o, 1'b0);
		cyc(2);
		r0 = rises;
		cyc(200);
		check(rises - r0, 0);
		check(mul_clk_o, 1'b0);
		rd(A, P, d);
		check(d, 8'h00);
	endtask

	// Reset in mid-run clears the register and the output
	task automatic t_midreset();
		logic [7:0] d;
		bring_up(2'b01, 3'b100);
		nrst_i = 1'b0;
		cyc(2);
		check({mul_clk_o, multiplier_enable_o, multiplier_ready_o}, 3'b000);
		nrst_i = 1'b1;
		rd(A, P, d);
		check(d, 8'h00);
	endtask

	initial begin
		cyc(16);
		nrst_i = 1'b1;
		t_reset();
		t_refused();
		t_scale();
		t_disable();
		t_midreset();
		complete_run();
	end
endmodule
